// ---- include/pixel_hit_tot_storage_regs.svh ----
// offsets, field positions, reset values and counts of the pixel hit block
//
// What this block does
// - each hit feeds a readout path and a column OR path, each enabled.
// - enabled pixel hits drive the shared column OR line of the core.
// - hit source is either discriminator output or digital injection pulse.
// - injection, readout and OR enables per pixel; digital injection global.
// - sample each readout-enabled hit level into the clock domain through a synchroniser chain.
// - leading pulse marks timestamp; trailing pulse triggers storing count.
// - each pixel counts pulse width on the crossing clock, six bits.
// - fine mode takes end-of-count clock phase as count LSB.
// - fine mode only by global bit; plain counting by default.
// - six-bit count kept, only a four-bit code stored and read.
// - global compression mode maps six-bit count to four-bit code.
// - uncompressed stores four LSBs unmapped; count saturates at 14.
// - compressed: 0-8 direct, 11..27 step four to 9..13, 31+ to 14.
// - default mode code equals lower edge of the count bin.
// - code 15 never stored for a hit; it marks an unhit entry.
// - count reaching maximum with input still high ends conversion.
// - region clock enable drops while no pixel is counting and no leading pulse is present.
// - each pixel has eight storage entries of four bits.
// - count written on trailing pulse or on reaching maximum.
// - common write address latched per pixel at conversion start.
// - one entry per pixel presented, picked by a read address.
`ifndef PIXEL_HIT_TOT_STORAGE_REGS_SVH
`define PIXEL_HIT_TOT_STORAGE_REGS_SVH

`define OFS_GLOBAL_CFG 12'h000
`define OFS_PIXEL_CFG 12'h004
`define OFS_STATUS 12'h008

`define GCFG_DIG_INJ_BIT 0
`define GCFG_FINE_BIT 1
`define GCFG_COMPRESS_BIT 2
`define GCFG_WIDTH 3
`define GCFG_RESET 3'h0

`define PCFG_FIELD_STRIDE 4
`define PCFG_INJ_BIT 0
`define PCFG_DAQ_BIT 1
`define PCFG_OR_BIT 2
`define PCFG_RESET 3'h0

`define STAT_BUSY_LSB 0
`define STAT_CLK_EN_BIT 8
`define STAT_COL_OR_BIT 9

`define MEM_DEPTH 8
`define CODE_WIDTH 4
`define CNT_WIDTH 6
`define CODE_NOHIT 4'hF
`define CODE_MAX 4'hE
`define CNT_MAX_PLAIN 6'h0E
`define CNT_MAX_COMPRESSED 6'h1F
`define CNT_DIRECT_LIMIT 6'h08
`define CNT_SLOPE_START 6'h0B
`define CODE_SLOPE_BASE 4'h9

`endif

// ---- include/pixel_hit_tot_pkg.sv ----
// types shared by the pixel hit and pulse width storage block
package pixel_hit_tot_pkg;

  typedef enum logic [0:0] {
    PIX_IDLE = 1'b0,
    PIX_COUNT = 1'b1
  } pix_phase_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    pix_phase_type phase;
    logic [5:0] cnt;
    logic [2:0] waddr;
  } pix_state_type;

  typedef struct packed {
    logic dig_inj_en;
    logic fine_en;
    logic compress_en;
  } global_cfg_type;

  typedef struct packed {
    logic or_en;
    logic daq_en;
    logic inj_en;
  } pixel_cfg_type;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

endpackage

// ---- src/pixel_hit_tot_storage.sv ----
// pixel hit processing, pulse width counting and storage for one region
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "pixel_hit_tot_storage_regs.svh"

module pixel_hit_tot_storage #(
  parameter int NPIX = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire pixel_hit_tot_pkg::apb_req_type apb_req,
  output pixel_hit_tot_pkg::apb_rsp_type apb_rsp,
  input wire logic [NPIX-1:0] disc_hit,
  input wire logic [NPIX-1:0] disc_fall_phase,
  input wire logic dig_inj_pulse,
  input wire logic [2:0] wr_addr,
  input wire logic [2:0] rd_addr,
  output logic [NPIX-1:0] daq_hit,
  output logic [NPIX-1:0] wired_or_hit_path,
  output logic column_or_line,
  output logic [NPIX-1:0] hit_leading_pulse,
  output logic [NPIX-1:0] hit_trailing_pulse,
  output logic region_clk_en,
  output logic [NPIX-1:0][3:0] tot_code
);

  localparam int DEPTH = `MEM_DEPTH;

  // status keeps busy bits below bit 8 and each pixel owns one nibble of
  // the pixel configuration word, so more than eight pixels cannot fit
  if (NPIX < 1 || NPIX > 8) begin : g_bad_npix
    $error("NPIX must lie between 1 and 8");
  end

  typedef struct packed {
    pixel_hit_tot_pkg::global_cfg_type gcfg;
    pixel_hit_tot_pkg::pixel_cfg_type [NPIX-1:0] pcfg;
    pixel_hit_tot_pkg::pix_state_type [NPIX-1:0] pix;
    logic [NPIX-1:0][DEPTH-1:0][3:0] mem;
    logic [NPIX-1:0][3:0] rd_data;
    logic [31:0] prdata;
    logic pslverr;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  //////////////////////////////////////////////////////////////////////////
  // count to code mapping

  function automatic logic [3:0] compress_code(input logic [5:0] cnt);
    logic [5:0] slope;
    slope = cnt - `CNT_SLOPE_START;
    if (cnt >= `CNT_MAX_COMPRESSED) begin
      compress_code = `CODE_MAX;
    end else if (cnt >= `CNT_SLOPE_START) begin
      compress_code = `CODE_SLOPE_BASE + slope[5:2];
    end else if (cnt > `CNT_DIRECT_LIMIT) begin
      // counts between the two slopes fall into the bin starting at 8
      compress_code = 4'(`CNT_DIRECT_LIMIT);
    end else begin
      compress_code = cnt[3:0];
    end
  endfunction

  function automatic logic [5:0] count_max(input logic compress);
    count_max = compress ? `CNT_MAX_COMPRESSED : `CNT_MAX_PLAIN;
  endfunction

  function automatic logic [3:0] make_code(input logic [5:0] cnt,
                                           input logic compress);
    logic [5:0] lim;
    lim = count_max(compress);
    if (compress) begin
      make_code = compress_code(cnt);
    end else if (cnt >= lim) begin
      make_code = `CODE_MAX;
    end else begin
      make_code = cnt[3:0];
    end
  endfunction

  function automatic logic [31:0] pcfg_word(
      input pixel_hit_tot_pkg::pixel_cfg_type [NPIX-1:0] pc);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < NPIX; i++) begin
      w[i*`PCFG_FIELD_STRIDE +: 3] = pc[i];
    end
    pcfg_word = w;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // hit source and path gating

  logic [NPIX-1:0] hit_src;
  logic [NPIX-1:0] busy;

  genvar g;
  generate
    for (g = 0; g < NPIX; g++) begin : g_pix
      // digital injection bypasses the front end
      assign hit_src[g] = state_r.gcfg.dig_inj_en ?
                          (dig_inj_pulse & state_r.pcfg[g].inj_en) :
                          disc_hit[g];
      assign daq_hit[g] = hit_src[g] & state_r.pcfg[g].daq_en;
      assign wired_or_hit_path[g] = hit_src[g] & state_r.pcfg[g].or_en;
      // edge pulses from the synchronised hit
      assign hit_leading_pulse[g] = state_r.pix[g].sync2 &
                                    ~state_r.pix[g].sync3;
      assign hit_trailing_pulse[g] = ~state_r.pix[g].sync2 &
                                     state_r.pix[g].sync3 &
                                     (state_r.pix[g].phase ==
                                      pixel_hit_tot_pkg::PIX_COUNT);
      assign busy[g] = state_r.pix[g].phase == pixel_hit_tot_pkg::PIX_COUNT;
      assign tot_code[g] = state_r.rd_data[g];
    end
  endgenerate

  // any enabled pixel pulls the column line
  assign column_or_line = |wired_or_hit_path;
  // clock runs while some pixel counts or a leading pulse is present
  assign region_clk_en = |busy | |hit_leading_pulse;

  //////////////////////////////////////////////////////////////////////////
  // next state

  logic apb_setup;
  logic apb_wr;

  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;

  always_comb begin
    logic [5:0] step;
    logic [5:0] lim;
    logic [5:0] sum;
    logic [5:0] fin;
    logic [31:0] status;
    pixel_hit_tot_pkg::pix_state_type p;
    step = 6'h01;
    lim = 6'h00;
    sum = 6'h00;
    fin = 6'h00;
    status = 32'h0000_0000;
    p = '0;
    state_nxt = state_r;
    // fine counting only when the global bit is set
    step = state_r.gcfg.fine_en ? 6'h02 : 6'h01;
    lim = count_max(state_r.gcfg.compress_en);

    for (int i = 0; i < NPIX; i++) begin
      p = state_r.pix[i];
      // hit level brought in through a synchroniser chain
      state_nxt.pix[i].sync1 = daq_hit[i];
      state_nxt.pix[i].sync2 = p.sync1;
      state_nxt.pix[i].sync3 = p.sync2;
      sum = p.cnt + step;
      if (p.sync2 && !p.sync3) begin
        // write slot fixed at conversion start
        state_nxt.pix[i].waddr = wr_addr;
        // counting starts on the first high cycle
        state_nxt.pix[i].cnt = step;
        state_nxt.pix[i].phase = pixel_hit_tot_pkg::PIX_COUNT;
        if (step >= lim) begin
          state_nxt.pix[i].phase = pixel_hit_tot_pkg::PIX_IDLE;
          state_nxt.mem[i][wr_addr] = `CODE_MAX;
        end
      end else if (p.phase == pixel_hit_tot_pkg::PIX_COUNT) begin
        if (p.sync2) begin
          if (sum >= lim) begin
            // saturated while still high ends the conversion
            state_nxt.pix[i].cnt = lim;
            state_nxt.pix[i].phase = pixel_hit_tot_pkg::PIX_IDLE;
            state_nxt.mem[i][p.waddr] =
              make_code(lim, state_r.gcfg.compress_en);
          end else begin
            state_nxt.pix[i].cnt = sum;
          end
        end else begin
          // end phase becomes the half-cycle LSB
          fin = p.cnt + {5'h00, state_r.gcfg.fine_en & disc_fall_phase[i]};
          if (fin > lim) begin
            fin = lim;
          end
          // only the four-bit code is kept
          state_nxt.mem[i][p.waddr] =
            make_code(fin, state_r.gcfg.compress_en);
          state_nxt.pix[i].phase = pixel_hit_tot_pkg::PIX_IDLE;
        end
      end
      state_nxt.rd_data[i] = state_r.mem[i][rd_addr];
    end

    status[`STAT_BUSY_LSB +: NPIX] = busy;
    status[`STAT_CLK_EN_BIT] = region_clk_en;
    status[`STAT_COL_OR_BIT] = column_or_line;

    // read data prepared in the setup cycle so the access phase has no wait
    if (apb_setup) begin
      state_nxt.pslverr = 1'b0;
      state_nxt.prdata = 32'h0000_0000;
      unique case (apb_req.paddr)
        `OFS_GLOBAL_CFG: begin
          state_nxt.prdata[`GCFG_DIG_INJ_BIT] = state_r.gcfg.dig_inj_en;
          state_nxt.prdata[`GCFG_FINE_BIT] = state_r.gcfg.fine_en;
          state_nxt.prdata[`GCFG_COMPRESS_BIT] = state_r.gcfg.compress_en;
        end
        `OFS_PIXEL_CFG: begin
          state_nxt.prdata = pcfg_word(state_r.pcfg);
        end
        `OFS_STATUS: begin
          state_nxt.prdata = status;
        end
        default: begin
          state_nxt.pslverr = 1'b1;
        end
      endcase
    end

    if (apb_wr) begin
      unique case (apb_req.paddr)
        `OFS_GLOBAL_CFG: begin
          // digital injection is one global bit
          state_nxt.gcfg.dig_inj_en = apb_req.pwdata[`GCFG_DIG_INJ_BIT];
          state_nxt.gcfg.fine_en = apb_req.pwdata[`GCFG_FINE_BIT];
          state_nxt.gcfg.compress_en = apb_req.pwdata[`GCFG_COMPRESS_BIT];
        end
        `OFS_PIXEL_CFG: begin
          for (int i = 0; i < NPIX; i++) begin
            state_nxt.pcfg[i].inj_en =
              apb_req.pwdata[i*`PCFG_FIELD_STRIDE + `PCFG_INJ_BIT];
            state_nxt.pcfg[i].daq_en =
              apb_req.pwdata[i*`PCFG_FIELD_STRIDE + `PCFG_DAQ_BIT];
            state_nxt.pcfg[i].or_en =
              apb_req.pwdata[i*`PCFG_FIELD_STRIDE + `PCFG_OR_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      // reset clears synchronisers, counters and conversions
      state_r <= '0;
      for (int i = 0; i < NPIX; i++) begin
        // empty entries hold the no-hit code
        for (int j = 0; j < DEPTH; j++) begin
          state_r.mem[i][j] <= `CODE_NOHIT;
        end
        state_r.rd_data[i] <= `CODE_NOHIT;
      end
    end else begin
      state_r <= state_nxt;
    end
  end

  // no wait states; errors only for unmapped offsets
  assign apb_rsp.prdata = state_r.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = state_r.pslverr & apb_req.psel & apb_req.penable;

endmodule

// ---- tb/region_ctrl_model.sv ----
// region control stand-in: write slot per leading pulse, read select
`timescale 1ns/100ps
module region_ctrl_model #(
  parameter int NPIX = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [NPIX-1:0] hit_leading_pulse,
  input wire logic [2:0] rd_sel,
  output logic [2:0] wr_addr,
  output logic [2:0] rd_addr
);
  // shared slot, moves on after a leading pulse
  always_ff @(posedge mclk)
    if (!rst_b)
      wr_addr <= 3'h0;
    else if (|hit_leading_pulse)
      wr_addr <= wr_addr + 3'h1;
  assign rd_addr = rd_sel;
endmodule

// ---- tb/pixel_hit_tot_storage_sva.sv ----
// port assertions for the pixel hit and pulse width storage block
`timescale 1ns/100ps
module hit_tot_sva #(
  parameter int NPIX = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [NPIX-1:0] daq_hit,
  input wire logic [NPIX-1:0] wired_or_hit_path,
  input wire logic column_or_line,
  input wire logic [NPIX-1:0] hit_leading_pulse,
  input wire logic [NPIX-1:0] hit_trailing_pulse,
  input wire logic region_clk_en,
  input wire logic [NPIX-1:0][3:0] tot_code
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  col_or_a: assert property (column_or_line == |wired_or_hit_path)
    else $error("column line differs");
  lead_one_a: assert property (hit_leading_pulse[0] |=>
    !hit_leading_pulse[0]) else $error("leading pulse too long");
  lead_time_a: assert property ($rose(daq_hit[0]) |-> ##2
    hit_leading_pulse[0]) else $error("leading pulse late");
  lead_cause_a: assert property (hit_leading_pulse[0] |->
    $past(daq_hit[0], 2)) else $error("leading pulse without hit");
  trail_cause_a: assert property (hit_trailing_pulse[0] |->
    !$past(daq_hit[0], 2)) else $error("trailing pulse while high");
  lead_clk_a: assert property (|hit_leading_pulse |->
    region_clk_en) else $error("clock gated at hit");
  idle_clk_a: assert property (!region_clk_en |->
    hit_trailing_pulse == '0) else $error("trailing pulse while idle");
  reset_clr_a: assert property (disable iff (1'b0) !rst_b |=>
    !region_clk_en && tot_code[0] == 4'hF) else $error("reset not clean");
endmodule
////////////////////////////////////////////////////////////////////////
bind pixel_hit_tot_storage hit_tot_sva #(.NPIX(NPIX)) hit_tot_sva_inst (
  .mclk, .rst_b, .daq_hit, .wired_or_hit_path, .column_or_line,
  .hit_leading_pulse, .hit_trailing_pulse, .region_clk_en, .tot_code);

// ---- tb/pixel_hit_tot_storage_tb.sv ----
// self-checking bench for the pixel hit and pulse width storage block
`timescale 1ns/100ps
`include "pixel_hit_tot_storage_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: check failed", $time); end end
module pixel_hit_tot_storage_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  pixel_hit_tot_pkg::apb_req_type apb_req = '0;
  pixel_hit_tot_pkg::apb_rsp_type apb_rsp;
  logic [3:0] disc_hit = '0;
  logic [3:0] disc_fall_phase = '0;
  logic dig_inj_pulse = 1'b0;
  logic [2:0] rd_sel = 3'h0;
  logic [2:0] wr_addr, rd_addr;
  logic [3:0] daq_hit, wired_or_hit_path, hit_leading_pulse;
  logic [3:0] hit_trailing_pulse;
  logic column_or_line, region_clk_en, rerr;
  logic [3:0][3:0] tot_code;
  logic [31:0] rdat;
  int n_fail = 0;
  int tests_run = 0;
  int slot = 0;
  always #5 mclk = ~mclk;
  pixel_hit_tot_storage #(.NPIX(4)) pixel_hit_tot_storage_inst (.mclk,
    .rst_b, .apb_req, .apb_rsp, .disc_hit, .disc_fall_phase,
    .dig_inj_pulse, .wr_addr, .rd_addr, .daq_hit, .wired_or_hit_path,
    .column_or_line, .hit_leading_pulse, .hit_trailing_pulse,
    .region_clk_en, .tot_code);
  region_ctrl_model #(.NPIX(4)) region_ctrl_model_inst (.mclk, .rst_b,
    .hit_leading_pulse, .rd_sel, .wr_addr, .rd_addr);
  ////////////////////////////////////////////////////////////////////////
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // request held until pready is seen at a rising edge; answer taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    apb_req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    i = 0;
    do begin @(posedge mclk); i++; end
      while (apb_rsp.pready !== 1'b1 && i < 50);
    if (apb_rsp.pready !== 1'b1) begin n_fail++; summarize(); end
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  function automatic logic [3:0] code(int n, bit f, bit c, bit ph);
    int t;
    t = f ? 2 * n + ph : n;
    if (!c) return (t > 14) ? 4'hE : 4'(t);
    if (t >= 31) return 4'hE;
    if (t > 8 && t < 11) return 4'h8;
    return (t <= 8) ? 4'(t) : 4'(9 + (t - 11) / 4);
  endfunction
  task hit(input int p, input int n, input bit inj, input logic oe,
    input logic [3:0] exp);
    int i;
    @(posedge mclk);
    if (inj) dig_inj_pulse <= 1'b1; else disc_hit[p] <= 1'b1;
    @(negedge mclk);
    `CHK(daq_hit[p], 1'b1)
    `CHK(column_or_line, oe)
    `CHK(wired_or_hit_path[p], oe)
    repeat (n) @(posedge mclk);
    if (inj) dig_inj_pulse <= 1'b0; else disc_hit[p] <= 1'b0;
    i = 0;
    do begin @(negedge mclk); i++; end
      while (region_clk_en !== 1'b0 && i < 99);
    if (i >= 99) begin n_fail++; summarize(); end
    @(posedge mclk);
    rd_sel <= 3'(slot);
    @(posedge mclk);
    @(negedge mclk);
    `CHK(tot_code[p], exp)
    slot++;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task plain_mode();
    apb(1'b1, `OFS_PIXEL_CFG, 32'h2666);
    hit(0, 3, 1'b0, 1'b1, code(3, 0, 0, 0));
    hit(3, 5, 1'b0, 1'b0, code(5, 0, 0, 0));
    hit(1, 20, 1'b0, 1'b1, code(20, 0, 0, 0));
  endtask
  task compress_mode();
    int n[3] = '{10, 12, 40};
    apb(1'b1, `OFS_GLOBAL_CFG, 32'h4);
    foreach (n[k]) hit(2, n[k], 1'b0, 1'b1, code(n[k], 0, 1, 0));
  endtask
  task fine_mode();
    apb(1'b1, `OFS_GLOBAL_CFG, 32'h2);
    disc_fall_phase <= 4'hF;
    hit(0, 3, 1'b0, 1'b1, code(3, 1, 0, 1));
    disc_fall_phase <= 4'h0;
  endtask
  task inject_mode();
    apb(1'b1, `OFS_PIXEL_CFG, 32'h2676);
    apb(1'b1, `OFS_GLOBAL_CFG, 32'h1);
    hit(1, 2, 1'b1, 1'b1, code(2, 0, 0, 0));
    apb(1'b0, `OFS_GLOBAL_CFG, 32'h0);
    `CHK(rdat[2:0], 3'h1)
  endtask
  task bad_addr();
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0)
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    `CHK(tot_code, {4{4'hF}})
    `CHK(region_clk_en, 1'b0)
    plain_mode();
    compress_mode();
    fine_mode();
    inject_mode();
    bad_addr();
    summarize();
  end
endmodule
